//--- hw/pigb_pkg.sv
package pigb_pkg;
    // register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] OFS_MODE   = 8'h00;
    localparam logic [7:0] OFS_REGCFG = 8'h04;
    localparam logic [7:0] OFS_DELAY  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_RXWORD = 8'h10;
    // operating modes of the pin logic
    localparam logic [3:0] MODE_BASIC  = 4'h0;
    localparam logic [3:0] MODE_SDR    = 4'h1;
    localparam logic [3:0] MODE_DDR_IN = 4'h2;
    localparam logic [3:0] MODE_DDR_OUT= 4'h3;
    localparam logic [3:0] MODE_DES4   = 4'h4;
    localparam logic [3:0] MODE_SER4   = 4'h5;
    localparam logic [3:0] MODE_DES7   = 4'h6;
    localparam logic [3:0] MODE_SER7   = 4'h7;
    localparam logic [3:0] MODE_DES8   = 4'h8;
    localparam logic [3:0] MODE_SER8   = 4'h9;
    localparam logic [3:0] MODE_DES10  = 4'ha;
    localparam logic [3:0] MODE_SER10  = 4'hb;
    // mode register fields
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned DIR_LSB  = 4;
    localparam logic [1:0] DIR_IN    = 2'h0;
    localparam logic [1:0] DIR_OUT   = 2'h1;
    localparam logic [1:0] DIR_BIDIR = 2'h2;
    localparam logic [1:0] DIR_TRI   = 2'h3;
    // per storage element config, one 6-bit slice per element
    localparam int unsigned CFG_W      = 6;
    localparam int unsigned CFG_CE_POL = 0;
    localparam int unsigned CFG_FALL   = 1;
    localparam int unsigned CFG_SR_LSB = 2;
    localparam int unsigned CFG_LATCH  = 5;
    localparam logic [2:0] SR_OFF      = 3'h0;
    localparam logic [2:0] SR_SYNC_RST = 3'h1;
    localparam logic [2:0] SR_SYNC_SET = 3'h2;
    localparam logic [2:0] SR_ASYN_RST = 3'h3;
    localparam logic [2:0] SR_ASYN_SET = 3'h4;
    localparam logic [17:0] RST_REGCFG = 18'h00_0001 | 18'h00040 | 18'h01000;
    // delay line
    localparam int unsigned DLY_W       = 7;
    localparam int unsigned DLY_STEPS   = 128;
    localparam int unsigned DLY_STEP_PS = 30;
    localparam int unsigned DLY_MAX_PS  = DLY_STEPS * DLY_STEP_PS;
    localparam int unsigned DLY_DYN_BIT = 7;
    localparam int unsigned DLY_OUT_BIT = 8;
    // status fields
    localparam int unsigned ST_EDGE_BIT  = 8;
    localparam int unsigned ST_CLAIM_BIT = 9;
    localparam int unsigned ST_MODE_LSB  = 12;
    // gearbox
    localparam int unsigned WORD_W = 10;
    localparam logic [3:0] RATIO_DDR = 4'h2;
endpackage

//--- hw/pigb_top.sv
`timescale 1ns/1ns
module pigb_top (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_nrst,
    input  wire logic [pigb_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [pigb_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    output logic      [pigb_pkg::DATA_W-1:0]  o_rdata,
    input  wire logic                         i_pad_in,
    output logic                              o_pad_out,
    output logic                              o_pad_oe,
    input  wire logic                         i_out_data,
    input  wire logic                         i_tri_ctrl,
    input  wire logic                         i_ce_out,
    input  wire logic                         i_ce_in,
    input  wire logic                         i_out_path_set_reset,
    input  wire logic                         i_in_path_set_reset,
    output logic                              o_in_data,
    input  wire logic [pigb_pkg::WORD_W-1:0]  i_tx_word,
    output logic                              o_tx_load,
    output logic      [pigb_pkg::WORD_W-1:0]  o_rx_word,
    output logic                              o_rx_valid,
    input  wire logic                         i_dly_step,
    input  wire logic                         i_dly_down,
    output logic      [pigb_pkg::DLY_W-1:0]   o_dly_in_code,
    output logic      [pigb_pkg::DLY_W-1:0]   o_dly_out_code,
    input  wire logic                         i_claimed_by_neighbor,
    output logic                              o_neighbor_claim
);
    localparam int unsigned NEL = 3;

    logic [5:0]                   mode_ff;
    logic [17:0]                  regcfg_ff;
    logic [8:0]                   dlycfg_ff;
    logic [pigb_pkg::DLY_W-1:0]   dly_code_ff;
    logic                         edge_flag_ff;
    logic                         neg_sample_ff;
    logic                         pos_sample_ff;
    logic [3:0]                   cnt_ff;
    logic [pigb_pkg::WORD_W-1:0]  sh_ff;
    logic [pigb_pkg::WORD_W-1:0]  rx_word_ff;
    logic                         rx_valid_ff;
    logic                         tx_load_ff;
    logic                         ser_bit_ff;
    logic [3:0]                   last_mode_ff;
    logic                         claim_ff;
    logic [pigb_pkg::DATA_W-1:0]  rdata_ff;
    logic [pigb_pkg::DLY_W-1:0]   dly_in_ff;
    logic [pigb_pkg::DLY_W-1:0]   dly_out_ff;

    // bus decode
    wire logic sel_mode   = (i_addr == pigb_pkg::OFS_MODE);
    wire logic sel_regcfg = (i_addr == pigb_pkg::OFS_REGCFG);
    wire logic sel_delay  = (i_addr == pigb_pkg::OFS_DELAY);
    wire logic sel_status = (i_addr == pigb_pkg::OFS_STATUS);
    wire logic sel_rxword = (i_addr == pigb_pkg::OFS_RXWORD);

    // effective mode: a claimed pin falls back to pass-through unless basic or sdr
    wire logic [3:0] mode_req = mode_ff[pigb_pkg::MODE_LSB +: 4];
    wire logic [1:0] dir      = mode_ff[pigb_pkg::DIR_LSB +: 2];
    wire logic req_simple = (mode_req == pigb_pkg::MODE_BASIC) || (mode_req == pigb_pkg::MODE_SDR);
    wire logic [3:0] mode = (i_claimed_by_neighbor && !req_simple) ?
                            pigb_pkg::MODE_BASIC : mode_req;

    // gearbox ratio and direction from mode
    wire logic [3:0] ratio =
        (mode == pigb_pkg::MODE_DDR_IN || mode == pigb_pkg::MODE_DDR_OUT) ? 4'h2 :
        (mode == pigb_pkg::MODE_DES4   || mode == pigb_pkg::MODE_SER4)    ? 4'h4 :
        (mode == pigb_pkg::MODE_DES7   || mode == pigb_pkg::MODE_SER7)    ? 4'h7 :
        (mode == pigb_pkg::MODE_DES8   || mode == pigb_pkg::MODE_SER8)    ? 4'h8 :
        (mode == pigb_pkg::MODE_DES10  || mode == pigb_pkg::MODE_SER10)   ? 4'ha :
        4'h0;
    wire logic gear_on  = (ratio != 4'h0);
    wire logic is_deser = gear_on && !mode[0];
    wire logic is_ser   = gear_on && mode[0];
    wire logic last_bit = (cnt_ff == ratio - 4'h1);
    wire logic wide_in  = (mode == pigb_pkg::MODE_DES7) || (mode == pigb_pkg::MODE_DES8) ||
                          (mode == pigb_pkg::MODE_DES10);

    // storage elements: 0 input capture, 1 output launch, 2 tristate control
    wire logic [NEL-1:0] el_d  = {i_tri_ctrl, i_out_data, i_pad_in};
    wire logic [NEL-1:0] el_ce = {i_ce_out, i_ce_out, i_ce_in};
    wire logic [NEL-1:0] el_sr = {i_out_path_set_reset, i_out_path_set_reset, i_in_path_set_reset};
    logic      [NEL-1:0] el_q;

    genvar k;
    generate
        for (k = 0; k < NEL; k++)
        begin : g_elem
            logic rise_ff;
            logic fall_ff;
            logic lat_q;
            wire logic [pigb_pkg::CFG_W-1:0] cfg = regcfg_ff[k*pigb_pkg::CFG_W +: pigb_pkg::CFG_W];
            wire logic [2:0] srm  = cfg[pigb_pkg::CFG_SR_LSB +: 3];
            wire logic ce_on = cfg[pigb_pkg::CFG_CE_POL] ? el_ce[k] : !el_ce[k];
            wire logic s_clr = el_sr[k] && (srm == pigb_pkg::SR_SYNC_RST);
            wire logic s_set = el_sr[k] && (srm == pigb_pkg::SR_SYNC_SET);
            wire logic a_clr = el_sr[k] && (srm == pigb_pkg::SR_ASYN_RST);
            wire logic a_set = el_sr[k] && (srm == pigb_pkg::SR_ASYN_SET);
            wire logic fall  = cfg[pigb_pkg::CFG_FALL];
            // rising-edge flop
            always_ff @(posedge i_ref_clk or negedge i_nrst or posedge a_clr or posedge a_set)
            begin
                if (!i_nrst)     rise_ff <= 1'b0;
                else if (a_clr)  rise_ff <= 1'b0;
                else if (a_set)  rise_ff <= 1'b1;
                else if (s_clr)  rise_ff <= 1'b0;
                else if (s_set)  rise_ff <= 1'b1;
                else if (ce_on)  rise_ff <= el_d[k];
            end
            // falling-edge flop
            always_ff @(negedge i_ref_clk or negedge i_nrst or posedge a_clr or posedge a_set)
            begin
                if (!i_nrst)     fall_ff <= 1'b0;
                else if (a_clr)  fall_ff <= 1'b0;
                else if (a_set)  fall_ff <= 1'b1;
                else if (s_clr)  fall_ff <= 1'b0;
                else if (s_set)  fall_ff <= 1'b1;
                else if (ce_on)  fall_ff <= el_d[k];
            end
            // level latch, open while the selected clock phase is active
            always_latch
            begin
                if (!i_nrst || a_clr)                   lat_q = 1'b0;
                else if (a_set)                         lat_q = 1'b1;
                else if (ce_on && (i_ref_clk != fall))  lat_q = el_d[k];
            end
            assign el_q[k] = cfg[pigb_pkg::CFG_LATCH] ? lat_q :
                             (fall ? fall_ff : rise_ff);
        end
    endgenerate

    // pad side muxing: pass-through, registered or gearbox
    wire logic ser_out = (mode == pigb_pkg::MODE_BASIC) ? i_out_data :
                         (mode == pigb_pkg::MODE_SDR)   ? el_q[1] :
                         ser_bit_ff;
    wire logic tri_sel = (mode == pigb_pkg::MODE_BASIC) ? i_tri_ctrl :
                         (mode == pigb_pkg::MODE_SDR)   ? el_q[2] :
                         i_tri_ctrl;
    assign o_pad_out = ser_out;
    assign o_pad_oe  = (dir == pigb_pkg::DIR_IN)  ? 1'b0 :
                       (dir == pigb_pkg::DIR_OUT) ? 1'b1 : !tri_sel;
    assign o_in_data = (mode == pigb_pkg::MODE_BASIC) ? i_pad_in : el_q[0];

    // register writes
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mode_ff   <= 6'h00;
            regcfg_ff <= pigb_pkg::RST_REGCFG;
            dlycfg_ff <= 9'h000;
        end
        else if (i_wr)
        begin
            if (sel_mode)   mode_ff   <= i_wdata[5:0];
            if (sel_regcfg) regcfg_ff <= i_wdata[17:0];
            if (sel_delay)  dlycfg_ff <= i_wdata[8:0];
        end
    end

    // delay code: static from register, or stepped at run time, saturating
    wire logic dly_dyn = dlycfg_ff[pigb_pkg::DLY_DYN_BIT];
    wire logic [pigb_pkg::DLY_W-1:0] dly_max = 7'(pigb_pkg::DLY_STEPS - 1);
    wire logic [pigb_pkg::DLY_W-1:0] nxt_dly_code =
        !dly_dyn ? dlycfg_ff[pigb_pkg::DLY_W-1:0] :
        (i_dly_step && !i_dly_down && dly_code_ff != dly_max) ? dly_code_ff + 7'h01 :
        (i_dly_step && i_dly_down && dly_code_ff != 7'h00) ? dly_code_ff - 7'h01 :
        dly_code_ff;
    wire logic dly_on_out = dlycfg_ff[pigb_pkg::DLY_OUT_BIT];
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            dly_code_ff <= 7'h00;
            dly_in_ff   <= 7'h00;
            dly_out_ff  <= 7'h00;
        end
        else
        begin
            dly_code_ff <= nxt_dly_code;
            dly_in_ff   <= dly_on_out ? 7'h00 : nxt_dly_code;
            dly_out_ff  <= dly_on_out ? nxt_dly_code : 7'h00;
        end
    end

    // edge monitor: pad sampled on both edges, mismatch in a ddr mode marks a transition near the edge
    always_ff @(negedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst) neg_sample_ff <= 1'b0;
        else         neg_sample_ff <= i_pad_in;
    end
    wire logic ddr_mode = (ratio == pigb_pkg::RATIO_DDR);
    wire logic edge_hit = ddr_mode && (pos_sample_ff != neg_sample_ff);
    wire logic edge_clr = i_wr && sel_status && i_wdata[pigb_pkg::ST_EDGE_BIT];
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pos_sample_ff <= 1'b0;
            edge_flag_ff  <= 1'b0;
        end
        else
        begin
            pos_sample_ff <= i_pad_in;
            edge_flag_ff  <= edge_hit || (edge_flag_ff && !edge_clr); // set wins
        end
    end

    // gearbox bit counter, restarted on reset or mode change
    wire logic mode_chg = (mode != last_mode_ff);
    wire logic [3:0] nxt_cnt = (!gear_on || mode_chg || last_bit) ? 4'h0 : cnt_ff + 4'h1;

    // deserializer: bit k of the word is the k-th bit seen on the pad
    logic [pigb_pkg::WORD_W-1:0] nxt_sh;
    always_comb
    begin
        nxt_sh = (mode_chg || cnt_ff == 4'h0) ? '0 : sh_ff;
        if (is_deser)
            nxt_sh[cnt_ff] = i_pad_in;
    end

    // serializer: word bit 0 goes out first
    wire logic ser_load = is_ser && !mode_chg && (cnt_ff == 4'h0);
    wire logic [pigb_pkg::WORD_W-1:0] tx_mask = ~({pigb_pkg::WORD_W{1'b1}} << ratio);

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_ff       <= 4'h0;
            sh_ff        <= '0;
            rx_word_ff   <= '0;
            rx_valid_ff  <= 1'b0;
            tx_load_ff   <= 1'b0;
            ser_bit_ff   <= 1'b0;
            last_mode_ff <= pigb_pkg::MODE_BASIC;
        end
        else
        begin
            cnt_ff       <= nxt_cnt;
            last_mode_ff <= mode;
            tx_load_ff   <= ser_load;
            if (is_ser)
            begin
                sh_ff      <= ser_load ? ((i_tx_word & tx_mask) >> 1) : (sh_ff >> 1);
                ser_bit_ff <= ser_load ? i_tx_word[0] : sh_ff[0];
            end
            else
            begin
                sh_ff      <= nxt_sh;
                ser_bit_ff <= 1'b0;
            end
            rx_valid_ff <= is_deser && !mode_chg && last_bit;
            if (is_deser && !mode_chg && last_bit)
                rx_word_ff <= nxt_sh;
        end
    end

    // neighbour claim and read data
    wire logic [pigb_pkg::DATA_W-1:0] status_word =
        {16'h0000, mode, 2'b00, claim_ff, edge_flag_ff, 1'b0, dly_code_ff};
    wire logic [pigb_pkg::DATA_W-1:0] rd_mux =
        sel_mode   ? {26'h0, mode_ff} :
        sel_regcfg ? {14'h0, regcfg_ff} :
        sel_delay  ? {23'h0, dlycfg_ff} :
        sel_status ? status_word :
        sel_rxword ? {22'h0, rx_word_ff} : 32'h0000_0000;
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            claim_ff <= 1'b0;
            rdata_ff <= '0;
        end
        else
        begin
            claim_ff <= wide_in;
            rdata_ff <= i_rd ? rd_mux : '0;
        end
    end

    assign o_rdata          = rdata_ff;
    assign o_rx_word        = rx_word_ff;
    assign o_rx_valid       = rx_valid_ff;
    assign o_tx_load        = tx_load_ff;
    assign o_dly_in_code    = dly_in_ff;
    assign o_dly_out_code   = dly_out_ff;
    assign o_neighbor_claim = claim_ff;
endmodule

//--- tb/pigb_top_properties.sv
`timescale 1ns/1ns
// port-level checks on the pin logic
module pigb_chk (
    input wire logic                        i_ref_clk,
    input wire logic                        i_nrst,
    input wire logic                        i_rd,
    input wire logic [pigb_pkg::DATA_W-1:0] o_rdata,
    input wire logic                        o_tx_load,
    input wire logic [pigb_pkg::WORD_W-1:0] o_rx_word,
    input wire logic                        o_rx_valid,
    input wire logic [pigb_pkg::DLY_W-1:0]  o_dly_in_code,
    input wire logic [pigb_pkg::DLY_W-1:0]  o_dly_out_code,
    input wire logic                        i_claimed_by_neighbor,
    input wire logic                        o_neighbor_claim
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    // read data only stands in the cycle after a read strobe
    property p_rdata_idle; !$past(i_rd) |-> o_rdata == '0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
    // a parallel word only changes together with its valid pulse
    property p_rx_hold; $changed(o_rx_word) |-> o_rx_valid; endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx word moved without valid");
    // every ratio is at least two, so valid and load are single pulses
    property p_rx_pulse; o_rx_valid |=> !o_rx_valid; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid too long");
    property p_tx_pulse; o_tx_load |=> !o_tx_load; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx load too long");
    // one pin is never deserializing and serializing at once
    property p_dir_excl; !(o_rx_valid && o_tx_load); endproperty
    a_dir_excl: assert property (p_dir_excl) else $error("rx and tx at once");
    // the delay code sits on one path only
    property p_dly_excl; o_dly_in_code == '0 || o_dly_out_code == '0; endproperty
    a_dly_excl: assert property (p_dly_excl) else $error("delay on both paths");
    // a claimed pin falls back to a plain mode, so the gearbox is silent
    property p_claimed; i_claimed_by_neighbor [*3] |-> !o_rx_valid && !o_tx_load; endproperty
    a_claimed: assert property (p_claimed) else $error("gearbox active on claimed pin");
    // a wide input mode never serializes
    property p_claim_in; o_neighbor_claim |-> !o_tx_load; endproperty
    a_claim_in: assert property (p_claim_in) else $error("load in wide input mode");
    // after entering a wide input mode no word appears in the five cycles after the claim rises
    property p_first_word; $rose(o_neighbor_claim) |=> !o_rx_valid [*5]; endproperty
    a_first_word: assert property (p_first_word) else $error("word before full count");

    c_rx: cover property (o_rx_valid);
    c_tx: cover property (o_tx_load);
    c_claim: cover property (o_neighbor_claim && o_rx_valid);
endmodule

bind pigb_top pigb_chk chk_u (.i_ref_clk, .i_nrst, .i_rd, .o_rdata, .o_tx_load, .o_rx_word,
    .o_rx_valid, .o_dly_in_code, .o_dly_out_code, .i_claimed_by_neighbor, .o_neighbor_claim);

//--- tb/pigb_pad_model.sv
`timescale 1ns/1ns
// far-side device on the pad wire
module pigb_pad_model (
    input  wire logic i_ref_clk,
    input  wire logic i_pad_out,
    input  wire logic i_pad_oe,
    output logic      o_pad_in
);
    logic drv_ff;
    logic hold_ff;

    // pin drive wins on the shared wire while its enable is high
    assign o_pad_in = i_pad_oe ? i_pad_out : drv_ff;

    // idle level flips each cycle so stale bits never pass for data
    initial drv_ff = 1'b0;
    initial hold_ff = 1'b0;
    always @(posedge i_ref_clk)
        if (!hold_ff)
            drv_ff <= ~drv_ff;

    // called just after a rising edge; the level holds for one full bit
    task automatic put(input logic b);
        hold_ff = 1'b1;
        drv_ff <= b;
    endtask
    task automatic idle();
        hold_ff = 1'b0;
    endtask
endmodule

//--- tb/pigb_top_tb_top.sv
`timescale 1ns/1ns
module pigb_top_tb_top;
    logic                        i_ref_clk, i_nrst, i_wr, i_rd, i_pad_in, i_out_data;
    logic                        i_tri_ctrl, i_ce_out, i_ce_in, i_dly_step, i_dly_down;
    logic                        i_out_path_set_reset, i_in_path_set_reset, i_claimed_by_neighbor;
    logic                        o_pad_out, o_pad_oe, o_in_data, o_tx_load, o_rx_valid;
    logic                        o_neighbor_claim, rd_d;
    logic [pigb_pkg::ADDR_W-1:0] i_addr;
    logic [pigb_pkg::DATA_W-1:0] i_wdata, o_rdata;
    logic [pigb_pkg::WORD_W-1:0] i_tx_word, o_rx_word, w, sh;
    logic [pigb_pkg::DLY_W-1:0]  o_dly_in_code, o_dly_out_code;
    logic [31:0]                 rd_q[$];
    logic [9:0]                  rx_q[$], tx_q[$];
    int                          nn[5], err_count, cmp_count, tx_n, tx_k, g;

    pigb_top dut_u (.i_ref_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pad_in,
        .o_pad_out, .o_pad_oe, .i_out_data, .i_tri_ctrl, .i_ce_out, .i_ce_in,
        .i_out_path_set_reset, .i_in_path_set_reset, .o_in_data, .i_tx_word, .o_tx_load,
        .o_rx_word, .o_rx_valid, .i_dly_step, .i_dly_down, .o_dly_in_code, .o_dly_out_code,
        .i_claimed_by_neighbor, .o_neighbor_claim);
    pigb_pad_model pad_u (.i_ref_clk, .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
        .o_pad_in(i_pad_in));

    // 125 MHz reference clock
    initial
    begin
        i_ref_clk = 1'b0;
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // comparison helpers, one per kind of result
    task automatic note(input logic ok, input string what);
        cmp_count++;
        if (!ok)
        begin
            err_count++;
            $display("[ERR] %0t mismatch on %s", $time, what);
        end
    endtask
    task automatic chk_reg(input logic [31:0] g1, input logic [31:0] e1);
        note(g1 === e1, "register or code");
    endtask
    task automatic chk_word(input logic [9:0] g1, input logic [9:0] e1);
        note(g1 === e1, "gearbox word");
    endtask
    task automatic chk_pin(input logic g1, input logic e1);
        note(g1 === e1, "pin level");
    endtask

    // register bus master, entered just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        @(posedge i_ref_clk);
    endtask
    task automatic sdr_in(input logic b, input logic ce, input logic e);
        pad_u.put(b);
        i_ce_in <= ce;
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk_pin(o_in_data, e);
        @(posedge i_ref_clk);
    endtask
    task automatic wait_load();
        g = 0;
        do @(posedge i_ref_clk); while (o_tx_load !== 1'b1 && ++g < 24);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // output watchers: read answers, received words, serialized pad bits
    always @(posedge i_ref_clk)
    begin
        if (rd_d && rd_q.size() > 0)
            chk_reg(o_rdata, rd_q.pop_front());
        rd_d <= i_rd;
        if (o_rx_valid === 1'b1 && rx_q.size() > 0)
            chk_word(o_rx_word, rx_q.pop_front());
        if (o_tx_load === 1'b1)
            tx_k = 0;
        if (tx_k == 0)
            sh = '0;
        if (tx_k < tx_n)
        begin
            sh[tx_k] = o_pad_out;
            tx_k++;
            if (tx_k == tx_n && tx_q.size() > 0)
                chk_word(sh, tx_q.pop_front());
        end
    end

    // watchdog, far beyond the few hundred cycles the tests take
    initial
    begin
        #160000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial
    begin
        {i_wr, i_rd, i_out_data, i_tri_ctrl, i_dly_step, i_dly_down, rd_d} = '0;
        {i_out_path_set_reset, i_in_path_set_reset, i_claimed_by_neighbor, i_nrst} = '0;
        {i_ce_out, i_ce_in} = 2'h3;
        {i_addr, i_wdata, i_tx_word} = '0;
        {err_count, cmp_count, tx_n, tx_k} = '0;
        nn = '{2, 4, 7, 8, 10};
        void'($urandom(55));
        repeat (20) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        @(posedge i_ref_clk);
        // reset values and an unmapped address
        rd(pigb_pkg::OFS_MODE, 32'h0);
        rd(pigb_pkg::OFS_REGCFG, 32'h01041);
        rd(pigb_pkg::OFS_DELAY, 32'h0);
        rd(pigb_pkg::OFS_STATUS, 32'h0);
        rd(pigb_pkg::OFS_RXWORD, 32'h0);
        rd(8'h20, 32'h0);
        $display("reset values done");
        // pass-through in every direction
        for (int d = 0; d < 4; d++)
        begin
            wr(pigb_pkg::OFS_MODE, 32'(d) << 4);
            repeat (4)
            begin
                i_out_data <= 1'($urandom);
                i_tri_ctrl <= 1'($urandom);
                @(negedge i_ref_clk);
                chk_pin(o_pad_out, i_out_data);
                chk_pin(o_in_data, i_pad_in);
                chk_pin(o_pad_oe, d == 0 ? 1'b0 : d == 1 ? 1'b1 : !i_tri_ctrl);
                @(posedge i_ref_clk);
            end
        end
        $display("pass-through done");
        // single-rate registers: enable polarity, set/reset kinds, falling edge
        wr(pigb_pkg::OFS_MODE, 32'h11);
        i_tri_ctrl <= 1'b0;
        i_out_data <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_out_data <= 1'b1;
        @(negedge i_ref_clk);
        chk_pin(o_pad_out, 1'b0);
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk_pin(o_pad_out, 1'b1);
        @(posedge i_ref_clk);
        wr(pigb_pkg::OFS_MODE, 32'h01);
        sdr_in(1'b1, 1'b1, 1'b1);
        sdr_in(1'b0, 1'b0, 1'b1);
        wr(pigb_pkg::OFS_REGCFG, 32'h01040);
        sdr_in(1'b0, 1'b0, 1'b0);
        sdr_in(1'b1, 1'b1, 1'b0);
        wr(pigb_pkg::OFS_REGCFG, 32'h01044);
        i_in_path_set_reset <= 1'b1;
        sdr_in(1'b1, 1'b0, 1'b0);
        wr(pigb_pkg::OFS_REGCFG, 32'h01051);
        i_in_path_set_reset <= 1'b0;
        sdr_in(1'b0, 1'b1, 1'b0);
        i_in_path_set_reset <= 1'b1;
        @(negedge i_ref_clk);
        chk_pin(o_in_data, 1'b1);
        @(posedge i_ref_clk);
        i_in_path_set_reset <= 1'b0;
        wr(pigb_pkg::OFS_REGCFG, 32'h01043);
        pad_u.put(1'b0);
        repeat (2) @(posedge i_ref_clk);
        pad_u.put(1'b1);
        @(negedge i_ref_clk);
        #1;
        chk_pin(o_in_data, 1'b1);
        @(posedge i_ref_clk);
        wr(pigb_pkg::OFS_REGCFG, 32'h01061);
        pad_u.put(1'b0);
        #1;
        chk_pin(o_in_data, 1'b0);
        @(posedge i_ref_clk);
        wr(pigb_pkg::OFS_REGCFG, 32'h01041);
        $display("single-rate done");
        // deserializing modes: three words each, bit 0 first
        for (int m = 0; m < 5; m++)
        begin
            wr(pigb_pkg::OFS_MODE, 32'(pigb_pkg::MODE_DDR_IN) + 32'(2 * m));
            repeat (3)
            begin
                w = 10'($urandom);
                for (int k = 0; k < nn[m]; k++)
                begin
                    pad_u.put(w[k]);
                    @(posedge i_ref_clk);
                end
                rx_q.push_back(w & ((10'h1 << nn[m]) - 10'h1));
                chk_pin(o_neighbor_claim, m >= 2);
            end
            pad_u.idle();
            repeat (3) @(posedge i_ref_clk);
            chk_reg(32'(rx_q.size()), 32'h0);
        end
        rd(pigb_pkg::OFS_STATUS, 32'ha300);
        wr(pigb_pkg::OFS_STATUS, 32'h100);
        rd(pigb_pkg::OFS_STATUS, 32'ha200);
        $display("deserialize done");
        // serializing modes: words follow each load pulse
        for (int m = 0; m < 5; m++)
        begin
            tx_n = 0;
            w = 10'($urandom);
            i_tx_word <= w;
            tx_q.push_back(w & ((10'h1 << nn[m]) - 10'h1));
            wr(pigb_pkg::OFS_MODE, 32'h10 + 32'(pigb_pkg::MODE_DDR_OUT) + 32'(2 * m));
            tx_n = nn[m];
            tx_k = 16;
            repeat (3)
            begin
                wait_load();
                w = 10'($urandom);
                i_tx_word <= w;
                tx_q.push_back(w & ((10'h1 << nn[m]) - 10'h1));
            end
            wait_load();
            repeat (12) @(posedge i_ref_clk);
            chk_reg(32'(tx_q.size()), 32'h0);
        end
        $display("serialize done");
        // delay codes: static on each path, dynamic with saturation
        wr(pigb_pkg::OFS_DELAY, 32'h07f);
        @(negedge i_ref_clk);
        chk_reg({o_dly_in_code, o_dly_out_code}, {7'h7f, 7'h0});
        @(posedge i_ref_clk);
        wr(pigb_pkg::OFS_DELAY, 32'h17e);
        wr(pigb_pkg::OFS_DELAY, 32'h1fe);
        i_dly_step <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_dly_step <= 1'b0;
        @(negedge i_ref_clk);
        chk_reg({o_dly_in_code, o_dly_out_code}, {7'h0, 7'h7f});
        @(posedge i_ref_clk);
        i_dly_down <= 1'b1;
        i_dly_step <= 1'b1;
        @(posedge i_ref_clk);
        i_dly_step <= 1'b0;
        @(negedge i_ref_clk);
        chk_reg(32'(o_dly_out_code), 32'h7e);
        $display("delay done");
        // claimed pin falls back to pass-through
        @(posedge i_ref_clk);
        i_claimed_by_neighbor <= 1'b1;
        wr(pigb_pkg::OFS_MODE, 32'h15);
        repeat (4)
        begin
            i_out_data <= 1'($urandom);
            @(negedge i_ref_clk);
            chk_pin(o_pad_out, i_out_data);
            @(posedge i_ref_clk);
        end
        i_claimed_by_neighbor <= 1'b0;
        $display("claim done");
        report_and_stop();
    end
endmodule
